// file: dpts_pkg.sv
/*
 * dpts_pkg: constants for the dual process timer sequencer.
 * assumes a single 125 MHz clock and an AHB-Lite register slave.
 */
package dpts_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_FREQ_HZ    = 125_000_000;
	localparam int SEC_TIME_S     = 1;
	localparam int VERSION_TIME_S = 3;
	localparam int HOLD_TIME_S    = 2;
	localparam int SEC_CYCLES     = SEC_TIME_S * CLK_FREQ_HZ;
	localparam int HOLD_CYCLES    = HOLD_TIME_S * CLK_FREQ_HZ;
	localparam logic [5:0] MINOR_MAX  = 6'h3B;
	localparam logic [2:0] CYCLE_LAST = 3'h6;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] PRIM_OFS   = 8'h04;
	localparam logic [7:0] SECD_OFS   = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	localparam logic [7:0] PANEL_OFS  = 8'h10;

	// ****************************************
	// control field positions
	// ****************************************
	localparam int CTRL_RUN     = 0;
	localparam int CTRL_ENDOFF  = 1;
	localparam int CTRL_DIR     = 2;
	localparam int CTRL_BASE    = 3;
	localparam int CTRL_START   = 4;
	localparam int CTRL_CLEAR   = 5;
	localparam int CTRL_TUNE    = 6;
	localparam int CTRL_MAN     = 7;
	localparam int CTRL_STOPPED = 8;
	localparam int CTRL_PROT    = 9;
	localparam int CTRL_PCYC    = 10;
	localparam logic [12:0] CTRL_RESET = 13'h0000;
	// interval word: minor in [5:0], major in [14:8]
	localparam logic [14:0] INTERVAL_RESET = 15'h0000;

	typedef enum logic [1:0] {PH_IDLE, PH_PRIMARY, PH_SECONDARY, PH_DONE} dpts_phase_t;
	typedef enum logic [1:0] {SCR_VERSION, SCR_PV_SP, SCR_SCAN, SCR_PARAM} dpts_screen_t;
endpackage

// file: dpts_top.sv
/*
 * dpts_top: two chained process timers, front-panel lamps, power-on
 * display sequence and key navigation, with an AHB-Lite register slave.
 * assumes one hready master, word accesses only, raw panel pins.
 */
`timescale 1ns/100ps
module dpts_top
	import dpts_pkg::*;
#(
	parameter int SEC_CYC  = SEC_CYCLES,
	parameter int HOLD_CYC = HOLD_CYCLES,
	parameter logic [7:0] SW_VERSION = 8'h10 // arbitrary value
)(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// panel pins
	input  wire logic        key_param_n,
	input  wire logic        key_back_n,
	input  wire logic        comm_activity,
	input  wire logic        ctrl_out_state,
	input  wire logic        usb_attached,
	// outputs and lamps
	output logic             control_enable,
	output logic             timer_out_primary,
	output logic             timer_out_secondary,
	output logic             first_timer_lamp,
	output logic             second_timer_lamp,
	output logic             autotune_lamp,
	output logic             manual_mode_lamp,
	output logic             run_lamp,
	output logic             comm_lamp,
	output logic             out_lamp,
	// display
	output logic [1:0]       disp_screen,
	output logic [2:0]       disp_cycle,
	output logic [3:0]       disp_param,
	output logic             disp_password,
	output logic [7:0]       disp_version,
	output logic [14:0]      disp_count
);
	// ****************************************
	// functions
	// ****************************************
	function automatic logic [14:0] step_time(input logic [14:0] t, input logic down);
		logic [6:0] mj;
		logic [5:0] mn;
		mj = t[14:8];
		mn = t[5:0];
		if (down) begin
			if (mn == 6'h00) begin
				mn = MINOR_MAX;
				mj = mj - 7'h01;
			end else begin
				mn = mn - 6'h01;
			end
		end else begin
			if (mn == MINOR_MAX) begin
				mn = 6'h00;
				mj = mj + 7'h01;
			end else begin
				mn = mn + 6'h01;
			end
		end
		return {mj, 2'b00, mn};
	endfunction

	function automatic logic [2:0] next_cycle(input logic [2:0] c);
		return (c == CYCLE_LAST) ? 3'h0 : c + 3'h1;
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= 5'h03;
			sync2_reg <= 5'h03;
		end else begin
			sync1_reg <= {usb_attached, ctrl_out_state, comm_activity, key_back_n, key_param_n};
			sync2_reg <= sync1_reg;
		end
	end
	wire logic pkey    = !sync2_reg[0];
	wire logic bkey    = !sync2_reg[1];
	wire logic comm_s  = sync2_reg[2];
	wire logic cout_s  = sync2_reg[3];
	wire logic usb_s   = sync2_reg[4];

	// ****************************************
	// ahb-lite slave
	// ****************************************
	logic        dph_wr_reg;
	logic [7:0]  dph_addr_reg;
	logic [12:0] ctrl_reg;
	logic [14:0] prim_reg;
	logic [14:0] secd_reg;
	logic [14:0] count_reg;
	dpts_phase_t  phase_reg;
	dpts_screen_t screen_reg;
	logic [2:0]  cycle_reg;
	logic [3:0]  param_reg;
	wire logic accept = hsel && hready && htrans[1];
	wire logic wr_ctrl = dph_wr_reg && dph_addr_reg == CTRL_OFS;
	wire logic start_cmd = wr_ctrl && hwdata[CTRL_START];
	wire logic clear_cmd = wr_ctrl && hwdata[CTRL_CLEAR];
	logic [31:0] rd_mux;
	always_comb begin
		case (haddr[7:0])
			CTRL_OFS:   rd_mux = {19'h0, ctrl_reg};
			PRIM_OFS:   rd_mux = {17'h0, prim_reg};
			SECD_OFS:   rd_mux = {17'h0, secd_reg};
			STATUS_OFS: rd_mux = {14'h0, usb_s, phase_reg, count_reg};
			PANEL_OFS:  rd_mux = {22'h0, screen_reg, cycle_reg, param_reg, disp_password};
			default:    rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dph_wr_reg   <= 1'b0;
			dph_addr_reg <= 8'h00;
			hrdata       <= 32'h0000_0000;
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
		end else begin
			dph_wr_reg <= accept && hwrite;
			if (accept) begin
				dph_addr_reg <= haddr[7:0];
				if (!hwrite) begin
					hrdata <= rd_mux;
				end
			end
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	logic sec_end;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= CTRL_RESET;
			prim_reg <= INTERVAL_RESET;
			secd_reg <= INTERVAL_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= hwdata[12:0] & ~13'h0030;
			end
			// hardware disable beats a same-cycle software write
			if (sec_end && ctrl_reg[CTRL_ENDOFF]) begin
				ctrl_reg[CTRL_RUN] <= 1'b0;
			end
			if (dph_wr_reg && dph_addr_reg == PRIM_OFS) begin
				prim_reg <= hwdata[14:0];
			end
			if (dph_wr_reg && dph_addr_reg == SECD_OFS) begin
				secd_reg <= hwdata[14:0];
			end
		end
	end
	wire logic run     = ctrl_reg[CTRL_RUN];
	wire logic down    = ctrl_reg[CTRL_DIR];
	wire logic mmss    = ctrl_reg[CTRL_BASE];

	// ****************************************
	// one-second tick and unit tick
	// ****************************************
	logic [31:0] pre_reg;
	logic [5:0]  sec_in_min_reg;
	wire logic sec_tick = pre_reg == 32'(SEC_CYC - 1);
	wire logic blink    = pre_reg < 32'(SEC_CYC / 2);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pre_reg        <= 32'h0000_0000;
			sec_in_min_reg <= 6'h00;
		end else begin
			pre_reg <= sec_tick ? 32'h0000_0000 : pre_reg + 32'h0000_0001;
			if (sec_tick) begin
				sec_in_min_reg <= (sec_in_min_reg == MINOR_MAX) ? 6'h00 : sec_in_min_reg + 6'h01;
			end
		end
	end
	// minutes are built from whole seconds in the hours:minutes base
	wire logic unit_tick = sec_tick && (mmss || sec_in_min_reg == MINOR_MAX);

	// ****************************************
	// interval sequencer
	// ****************************************
	wire logic [14:0] target = (phase_reg == PH_PRIMARY) ? prim_reg : secd_reg;
	wire logic [14:0] goal   = down ? 15'h0000 : target;
	wire logic at_goal = count_reg == goal;
	wire logic prim_end = phase_reg == PH_PRIMARY && at_goal;
	assign sec_end = phase_reg == PH_SECONDARY && at_goal;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			phase_reg <= PH_IDLE;
			count_reg <= INTERVAL_RESET;
		end else if (clear_cmd) begin
			phase_reg <= PH_IDLE;
			count_reg <= INTERVAL_RESET;
		end else begin
			case (phase_reg)
				PH_IDLE, PH_DONE: begin
					if (start_cmd) begin
						phase_reg <= PH_PRIMARY;
						count_reg <= hwdata[CTRL_DIR] ? prim_reg : INTERVAL_RESET;
					end
				end
				PH_PRIMARY, PH_SECONDARY: begin
					if (prim_end) begin
						phase_reg <= PH_SECONDARY;
						count_reg <= down ? secd_reg : INTERVAL_RESET;
					end else if (sec_end) begin
						phase_reg <= PH_DONE;
					end else if (unit_tick && run) begin
						count_reg <= step_time(count_reg, down);
					end
				end
				default: phase_reg <= PH_IDLE;
			endcase
		end
	end

	// ****************************************
	// outputs and lamps
	// ****************************************
	logic [3:0] comm_hold_reg;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			comm_hold_reg <= 4'h0;
		end else if (comm_s) begin
			comm_hold_reg <= 4'hF;
		end else if (sec_tick && comm_hold_reg != 4'h0) begin
			comm_hold_reg <= comm_hold_reg - 4'h1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			control_enable      <= 1'b0;
			timer_out_primary   <= 1'b0;
			timer_out_secondary <= 1'b0;
			first_timer_lamp    <= 1'b0;
			second_timer_lamp   <= 1'b0;
			autotune_lamp       <= 1'b0;
			manual_mode_lamp    <= 1'b0;
			run_lamp            <= 1'b0;
			comm_lamp           <= 1'b0;
			out_lamp            <= 1'b0;
		end else begin
			control_enable      <= run;
			timer_out_primary   <= run && phase_reg == PH_PRIMARY;
			timer_out_secondary <= run && phase_reg == PH_SECONDARY;
			first_timer_lamp    <= phase_reg == PH_PRIMARY && blink;
			second_timer_lamp   <= phase_reg == PH_SECONDARY && blink;
			autotune_lamp       <= ctrl_reg[CTRL_TUNE];
			manual_mode_lamp    <= ctrl_reg[CTRL_MAN];
			run_lamp            <= run || (ctrl_reg[CTRL_STOPPED] && blink);
			comm_lamp           <= comm_hold_reg != 4'h0 && blink;
			out_lamp            <= run && cout_s;
		end
	end

	// ****************************************
	// display and key navigation
	// ****************************************
	logic [1:0]  boot_reg;
	logic [31:0] hold_reg;
	logic        pkey_d_reg;
	logic        bkey_d_reg;
	wire logic hold_due = pkey && hold_reg == 32'(HOLD_CYC - 1);
	wire logic p_release = pkey_d_reg && !pkey;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			boot_reg   <= 2'h0;
			hold_reg   <= 32'h0000_0000;
			pkey_d_reg <= 1'b0;
			bkey_d_reg <= 1'b0;
			screen_reg <= SCR_VERSION;
			cycle_reg  <= 3'h0;
			param_reg  <= 4'h0;
		end else begin
			pkey_d_reg <= pkey;
			bkey_d_reg <= bkey;
			hold_reg <= (!pkey || hold_due) ? 32'h0000_0000 : hold_reg + 32'h0000_0001;
			case (screen_reg)
				SCR_VERSION: begin
					if (sec_tick) begin
						boot_reg <= boot_reg + 2'h1;
					end
					if (sec_tick && boot_reg == 2'(VERSION_TIME_S - 1)) begin
						screen_reg <= SCR_PV_SP;
					end
				end
				SCR_PV_SP: begin
					if (pkey) begin
						screen_reg <= SCR_SCAN;
						cycle_reg  <= 3'h0;
						param_reg  <= 4'h0;
					end
				end
				SCR_SCAN: begin
					if (hold_due) begin
						cycle_reg <= next_cycle(cycle_reg);
					end else if (!pkey) begin
						screen_reg <= SCR_PARAM;
						param_reg  <= 4'h0;
					end
				end
				SCR_PARAM: begin
					if (hold_due) begin
						screen_reg <= SCR_SCAN;
						cycle_reg  <= next_cycle(cycle_reg);
					end else if (p_release) begin
						param_reg <= param_reg + 4'h1;
					end else if (bkey && !bkey_d_reg) begin
						param_reg <= param_reg - 4'h1;
					end
				end
				default: screen_reg <= SCR_VERSION;
			endcase
		end
	end
	// a release in the parameter screen is always short: a full hold has already left for scan

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			disp_screen   <= 2'h0;
			disp_cycle    <= 3'h0;
			disp_param    <= 4'h0;
			disp_password <= 1'b0;
			disp_version  <= 8'h00;
			disp_count    <= INTERVAL_RESET;
		end else begin
			disp_screen   <= screen_reg;
			disp_cycle    <= cycle_reg;
			disp_param    <= param_reg;
			disp_password <= ctrl_reg[CTRL_PROT] && cycle_reg == ctrl_reg[12:10]
				&& param_reg == 4'h0 && screen_reg != SCR_PV_SP;
			disp_version  <= SW_VERSION;
			disp_count    <= count_reg;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	a_seq_begins_primary: assert property ((phase_reg == PH_IDLE && start_cmd) |=> phase_reg == PH_PRIMARY) else $error("sequence did not start with primary");
	a_second_follows: assert property ((prim_end && !clear_cmd) |=> phase_reg == PH_SECONDARY) else $error("secondary did not follow primary");
	a_second_only_after: assert property ($rose(phase_reg == PH_SECONDARY) |-> $past(phase_reg) == PH_PRIMARY) else $error("secondary started alone");
	a_end_disables_run: assert property ((sec_end && ctrl_reg[CTRL_ENDOFF]) |=> !run ##1 !control_enable) else $error("run kept after end");
	a_end_keeps_run: assert property ((sec_end && !ctrl_reg[CTRL_ENDOFF] && run && !wr_ctrl) |=> run) else $error("run dropped without option");
	a_linked_output: assert property ((run && phase_reg == PH_PRIMARY) |=> timer_out_primary) else $error("primary output not on");
	a_second_lamp_dark: assert property ((phase_reg != PH_SECONDARY) |=> !second_timer_lamp) else $error("second lamp lit outside interval");
	a_up_from_zero: assert property (($rose(phase_reg == PH_PRIMARY) && !down) |-> count_reg == 15'h0000) else $error("ascending count not zero");
	a_down_from_value: assert property (($rose(phase_reg == PH_PRIMARY) && down) |-> count_reg == prim_reg) else $error("descending count not loaded");
	a_off_all_outputs: assert property (!run |=> !timer_out_primary && !timer_out_secondary && !out_lamp) else $error("output on while disabled");
	a_version_first: assert property ((screen_reg == SCR_VERSION) |-> boot_reg < 2'(VERSION_TIME_S)) else $error("version shown too long");
	a_clear_empties: assert property (clear_cmd |=> phase_reg == PH_IDLE ##1 !first_timer_lamp && !timer_out_primary) else $error("clear left timer active");

	c_full_sequence: cover property (phase_reg == PH_SECONDARY ##1 phase_reg == PH_DONE);
	c_cycle_advance: cover property (screen_reg == SCR_SCAN && hold_due);
	c_password_shown: cover property (disp_password);
	c_param_step: cover property (screen_reg == SCR_PARAM && p_release);
endmodule // dpts_top

// file: dpts_operator.sv
/*
 * dpts_operator: operator at the front panel: keys, network activity,
 * control output level and serial bridge presence.
 * assumes its tasks are called just after a rising clock edge.
 */
`timescale 1ns/100ps
module dpts_operator (
	// clock
	input  wire logic mclk,
	// panel
	output logic      key_param_n,
	output logic      key_back_n,
	output logic      comm_activity,
	output logic      ctrl_out_state,
	output logic      usb_attached
);
	initial begin
		key_param_n = 1'b1;
		key_back_n = 1'b1;
		comm_activity = 1'b0;
		ctrl_out_state = 1'b0;
		usb_attached = 1'b1;
	end
	// keys are held for whole cycles, then released to their idle high level
	task automatic press_param(input int hold);
		key_param_n <= 1'b0;
		repeat (hold) @(posedge mclk);
		key_param_n <= 1'b1;
	endtask
	task automatic press_back(input int hold);
		key_back_n <= 1'b0;
		repeat (hold) @(posedge mclk);
		key_back_n <= 1'b1;
	endtask
	task automatic pulse_comm();
		comm_activity <= 1'b1;
		repeat (3) @(posedge mclk);
		comm_activity <= 1'b0;
	endtask
	task automatic set_out(input logic v);
		ctrl_out_state <= v;
	endtask
endmodule // dpts_operator

// file: test_dual_process_timer_sequencer.sv
/*
 * test_dual_process_timer_sequencer: self-checking bench for dpts_top.
 * assumes short tick counts (SEC, HOLD) and a single ahb-lite master.
 */
`timescale 1ns/100ps
module test_dual_process_timer_sequencer
	import dpts_pkg::*;
;
	localparam int SEC = 20;
	localparam int HOLD = 50;
	localparam logic [7:0] VER = 8'h5A; // arbitrary value
	logic mclk, reset_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rdat;
	logic [1:0] htrans, disp_screen;
	logic [2:0] hsize, disp_cycle;
	logic key_param_n, key_back_n, comm_activity, ctrl_out_state, usb_attached;
	logic control_enable, timer_out_primary, timer_out_secondary;
	logic first_timer_lamp, second_timer_lamp, autotune_lamp, manual_mode_lamp;
	logic run_lamp, comm_lamp, out_lamp, disp_password;
	logic [3:0] disp_param;
	logic [7:0] disp_version;
	logic [14:0] disp_count;
	logic [31:0] pv, sv;
	int num_errors = 0;
	int comparisons = 0;

	dpts_top #(.SEC_CYC(SEC), .HOLD_CYC(HOLD), .SW_VERSION(VER)) dut (.mclk(mclk),
		.reset_n(reset_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .key_param_n(key_param_n), .key_back_n(key_back_n),
		.comm_activity(comm_activity), .ctrl_out_state(ctrl_out_state),
		.usb_attached(usb_attached), .control_enable(control_enable),
		.timer_out_primary(timer_out_primary), .timer_out_secondary(timer_out_secondary),
		.first_timer_lamp(first_timer_lamp), .second_timer_lamp(second_timer_lamp),
		.autotune_lamp(autotune_lamp), .manual_mode_lamp(manual_mode_lamp),
		.run_lamp(run_lamp), .comm_lamp(comm_lamp), .out_lamp(out_lamp),
		.disp_screen(disp_screen), .disp_cycle(disp_cycle), .disp_param(disp_param),
		.disp_password(disp_password), .disp_version(disp_version), .disp_count(disp_count));
	dpts_operator op (.mclk(mclk), .key_param_n(key_param_n), .key_back_n(key_back_n),
		.comm_activity(comm_activity), .ctrl_out_state(ctrl_out_state),
		.usb_attached(usb_attached));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// ****************************************
	// checks and bus cycles
	// ****************************************
	task automatic complete_run();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// the master waits for hready at both phases; a stuck slave ends the run
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		n = 0;
		do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 100);
		rdat = hrdata;
		if (n >= 100) begin
			num_errors++;
			complete_run();
		end
	endtask
	task automatic wait_phase(input logic [1:0] p, input int lim);
		int n;
		n = 0;
		do begin ahb(1'b0, STATUS_OFS, 32'h0); n++; end while (rdat[16:15] !== p && n < lim);
		if (rdat[16:15] !== p) begin
			num_errors++;
			complete_run();
		end
	endtask
	// a flashing lamp is seen both lit and dark within two ticks
	task automatic blink(input int sel);
		int hi;
		hi = 0;
		repeat (2 * SEC) begin
			@(posedge mclk);
			hi += ((sel == 0) ? run_lamp : (sel == 1) ? first_timer_lamp :
				(sel == 2) ? second_timer_lamp : comm_lamp) === 1'b1;
		end
		check(32'(hi > 0 && hi < 2 * SEC), 32'h1);
	endtask
	function automatic logic [31:0] start_count(input logic down, input logic [31:0] ival);
		return down ? {17'h0, ival[14:0]} : 32'h0;
	endfunction
	function automatic logic [31:0] run_after_end(input logic [31:0] c);
		return {31'h0, c[CTRL_RUN] & ~c[CTRL_ENDOFF]};
	endfunction

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(93671));
		reset_n = 1'b0;
		hsel = 1'b1;
		hsize = 3'h2;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (2 * SEC) @(posedge mclk);
		check(disp_screen, 32'h0);
		check(disp_version, {24'h0, VER});
		repeat (2 * SEC) @(posedge mclk);
		check(disp_screen, 32'h1);
		ahb(1'b0, 8'h14, 32'h0);
		check(rdat, 32'h0);
		check(hresp, 32'h0);
		ahb(1'b0, STATUS_OFS, 32'h0);
		check(rdat[17], 32'h1);
		for (int i = 0; i < 4; i++) begin
			ahb(1'b1, CTRL_OFS, 32'(i << 6));
			repeat (2) @(posedge mclk);
			check({autotune_lamp, manual_mode_lamp}, {i[0], i[1]});
		end
		// ascending, minutes:seconds, end option set
		pv = 32'(2 + $urandom % 2);
		sv = 32'(2 + $urandom % 2);
		ahb(1'b1, PRIM_OFS, pv);
		ahb(1'b1, SECD_OFS, sv);
		op.set_out(1'b1);
		ahb(1'b1, CTRL_OFS, 32'h1B);
		wait_phase(2'h1, 40);
		check({timer_out_primary, timer_out_secondary, out_lamp}, 32'h5);
		blink(1);
		wait_phase(2'h2, 200);
		check(rdat[14:0], start_count(1'b0, sv));
		check({timer_out_primary, timer_out_secondary}, 32'h1);
		blink(2);
		wait_phase(2'h3, 200);
		repeat (2) @(posedge mclk);
		check({control_enable, timer_out_secondary, second_timer_lamp}, 32'h0);
		check(out_lamp, 32'h0);
		ahb(1'b0, CTRL_OFS, 32'h0);
		check(rdat[0], run_after_end(32'h1B));
		// descending, hours:minutes, end option clear
		ahb(1'b1, PRIM_OFS, 32'h2);
		ahb(1'b1, SECD_OFS, 32'h1);
		ahb(1'b1, CTRL_OFS, 32'h15);
		wait_phase(2'h1, 40);
		repeat (30 * SEC) @(posedge mclk);
		ahb(1'b0, STATUS_OFS, 32'h0);
		check(rdat[16:15], 32'h1);
		wait_phase(2'h2, 1500);
		check(rdat[14:0], start_count(1'b1, 32'h1));
		check(disp_count, start_count(1'b1, 32'h1));
		wait_phase(2'h3, 1500);
		check(control_enable, run_after_end(32'h15));
		// clear in mid-interval
		ahb(1'b1, CTRL_OFS, 32'h11);
		wait_phase(2'h1, 40);
		ahb(1'b1, CTRL_OFS, 32'h21);
		ahb(1'b0, STATUS_OFS, 32'h0);
		check(rdat[16:15], 32'h0);
		check({timer_out_primary, timer_out_secondary, first_timer_lamp}, 32'h0);
		ahb(1'b1, CTRL_OFS, 32'h100);
		blink(0);
		ahb(1'b1, CTRL_OFS, 32'h601);
		repeat (3) @(posedge mclk);
		check({run_lamp, out_lamp}, 32'h3);
		op.set_out(1'b0);
		repeat (5) @(posedge mclk);
		check(out_lamp, 32'h0);
		op.pulse_comm();
		blink(3);
		// key navigation, protection starting at the tuning cycle
		fork
			op.press_param(HOLD + 20);
			begin
				repeat (10) @(posedge mclk);
				check({disp_screen, disp_cycle}, 32'h10);
				repeat (HOLD + 5) @(posedge mclk);
				check({disp_screen, disp_cycle, disp_password}, 32'h23);
			end
		join
		repeat (8) @(posedge mclk);
		check({disp_screen, disp_param, disp_password}, 32'h61);
		op.press_param(5);
		repeat (8) @(posedge mclk);
		check({disp_param, disp_password}, 32'h2);
		op.press_back(5);
		repeat (8) @(posedge mclk);
		check({disp_param, disp_password}, 32'h1);
		complete_run();
	end
endmodule // test_dual_process_timer_sequencer
